// file: rtl/pcs_pkg.sv
// program counter and return stack: shared constants and types
// assumes one clock domain; the core decoder and the APB master share pclk
package pcs_pkg;
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int LATCH_W = 5;
  localparam int JUMP_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int DATA_W = 32;
  localparam int APB_AW = 12;
  localparam int OP_W = 3;
  localparam int SEL_W = 2;

  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;

  // fields of the latch used by jumps and calls
  localparam int LATCH_JUMP_HI = 4;
  localparam int LATCH_JUMP_LO = 3;

  // APB register offsets (byte addresses)
  localparam logic [APB_AW-1:0] OFS_PC_LOW = 12'h000;
  localparam logic [APB_AW-1:0] OFS_PC_LATCH = 12'h004;
  localparam logic [APB_AW-1:0] OFS_CONFIG = 12'h008;
  localparam logic [APB_AW-1:0] OFS_STATUS = 12'h00C;

  // implemented program memory size select
  localparam logic [SEL_W-1:0] SEL_512 = 2'h0;
  localparam logic [SEL_W-1:0] SEL_1K = 2'h1;
  localparam logic [SEL_W-1:0] SEL_2K = 2'h2;
  localparam logic [PC_W-1:0] MASK_512 = 13'h01FF;
  localparam logic [PC_W-1:0] MASK_1K = 13'h03FF;
  localparam logic [PC_W-1:0] MASK_2K = 13'h07FF;

  // status register fields
  localparam int ST_OP_LSB = 0;
  localparam int ST_SEEN_BIT = 4;

  typedef enum logic [OP_W-1:0] {
    OP_SEQ,
    OP_JUMP,
    OP_CALL,
    OP_RETURN,
    OP_RETURN_WITH_LITERAL_OP,
    OP_RETURN_FROM_INTERRUPT_OP,
    OP_PCL_WRITE,
    OP_IRQ
  } pcs_op_type;
endpackage

// file: rtl/pcs_stack_if.sv
// push/pop carrier between the sequencer and the return stack
// assumes at most one of push and pop per cycle
`timescale 1ns/1ns
interface pcs_stack_if #(parameter int PC_W = 13);
  logic push;
  logic pop;
  logic [PC_W-1:0] push_data;
  logic [PC_W-1:0] pop_data;
  modport ctrl (output push, output pop, output push_data, input pop_data);
  modport store (input push, input pop, input push_data, output pop_data);
endinterface

// file: rtl/pcs_stack.sv
// circular return-address stack, no overflow or underflow indication
// assumes the controller never pushes and pops in one cycle
`timescale 1ns/1ns
module pcs_stack #(
  parameter int DEPTH = pcs_pkg::STACK_DEPTH,
  parameter int PC_W = pcs_pkg::PC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  pcs_stack_if.store st
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("stack depth must be a power of two");
    end
  endgenerate

  logic [PC_W-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] ptr_r;
  wire [PTR_W-1:0] top_idx = ptr_r - PTR_ONE;

  // pointer wraps freely: the ninth push lands on the first entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_r <= '0;
    end else if (st.push) begin
      ptr_r <= ptr_r + PTR_ONE;
    end else if (st.pop) begin
      ptr_r <= top_idx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (st.push) begin
      mem_r[ptr_r] <= st.push_data;
    end
  end

  // a pop past empty simply returns whatever the slot last held
  assign st.pop_data = mem_r[top_idx];
endmodule

// file: rtl/pcs_addr_wrap.sv
// folds a logical 13-bit address into the implemented program memory
// a selected size larger than the synthesised memory size is capped to the built size
`timescale 1ns/1ns
module pcs_addr_wrap #(
  parameter int MEM_WORDS = 2048
) (
  input wire logic [pcs_pkg::SEL_W-1:0] size_sel,
  input wire logic [pcs_pkg::PC_W-1:0] addr_in,
  output logic [pcs_pkg::PC_W-1:0] addr_out
);
  function automatic logic [pcs_pkg::PC_W-1:0] size_mask(input logic [pcs_pkg::SEL_W-1:0] sel);
    case (sel)
      pcs_pkg::SEL_512: size_mask = pcs_pkg::MASK_512;
      pcs_pkg::SEL_1K: size_mask = pcs_pkg::MASK_1K;
      default: size_mask = pcs_pkg::MASK_2K;
    endcase
  endfunction

  localparam logic [pcs_pkg::SEL_W-1:0] CAP_SEL =
    (MEM_WORDS == 512) ? pcs_pkg::SEL_512 :
    (MEM_WORDS == 1024) ? pcs_pkg::SEL_1K : pcs_pkg::SEL_2K;

  // software may pick a smaller variant, never one larger than built
  wire [pcs_pkg::PC_W-1:0] mask = size_mask(size_sel) & size_mask(CAP_SEL);
  assign addr_out = addr_in & mask;
endmodule

// file: rtl/pcs_pc_unit.sv
// program sequencer: 13-bit program counter, high-byte latch, return stack
// assumes the core decoder runs on pclk and presents one op per cycle at most
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ns
module pcs_pc_unit #(
  parameter int MEM_WORDS = 2048,
  parameter int STACK_DEPTH = pcs_pkg::STACK_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pcs_pkg::APB_AW-1:0] paddr,
  input wire logic [pcs_pkg::DATA_W-1:0] pwdata,
  output logic [pcs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire logic [pcs_pkg::OP_W-1:0] op_kind,
  input wire logic [pcs_pkg::JUMP_W-1:0] op_target,
  input wire logic [pcs_pkg::LOW_W-1:0] op_data,
  input wire logic latch_wr,
  input wire logic [pcs_pkg::LOW_W-1:0] latch_data,
  output logic [pcs_pkg::PC_W-1:0] fetch_addr,
  output logic [pcs_pkg::LOW_W-1:0] pc_low,
  output logic [pcs_pkg::LATCH_W-1:0] pc_high_latch
);
  localparam int PC_W = pcs_pkg::PC_W;
  localparam int LOW_W = pcs_pkg::LOW_W;
  localparam int LATCH_W = pcs_pkg::LATCH_W;
  localparam int DATA_W = pcs_pkg::DATA_W;
  localparam int SEL_W = pcs_pkg::SEL_W;
  localparam int OP_W = pcs_pkg::OP_W;

  localparam logic [SEL_W-1:0] SEL_RESET =
    (MEM_WORDS == 512) ? pcs_pkg::SEL_512 :
    (MEM_WORDS == 1024) ? pcs_pkg::SEL_1K : pcs_pkg::SEL_2K;

  generate
    if (MEM_WORDS != 512 && MEM_WORDS != 1024 && MEM_WORDS != 2048) begin : g_bad_mem
      $error("program memory must be 512, 1024 or 2048 words");
    end
    if (PC_W != LOW_W + LATCH_W) begin : g_bad_split
      $error("counter must split into low byte and latch width");
    end
  endgenerate

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [LATCH_W-1:0] latch_r;
  logic [LATCH_W-1:0] latch_nxt;
  logic [SEL_W-1:0] size_sel_r;
  logic [OP_W-1:0] last_op_r;
  logic op_seen_r;
  logic [DATA_W-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  pcs_stack_if #(.PC_W(PC_W)) stk ();

  pcs_stack #(
    .DEPTH(STACK_DEPTH),
    .PC_W(PC_W)
  ) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .st(stk.store)
  );

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire apb_setup = psel && !penable;
  wire apb_commit = psel && penable && pready_r;
  wire hit_low = (paddr == pcs_pkg::OFS_PC_LOW);
  wire hit_latch = (paddr == pcs_pkg::OFS_PC_LATCH);
  wire hit_config = (paddr == pcs_pkg::OFS_CONFIG);
  wire hit_status = (paddr == pcs_pkg::OFS_STATUS);
  wire hit_any = hit_low || hit_latch || hit_config || hit_status;
  wire sw_low_we = apb_commit && pwrite && hit_low;
  wire sw_latch_we = apb_commit && pwrite && hit_latch;
  wire sw_config_we = apb_commit && pwrite && hit_config;

  // the stack and its pointer have no address at all
  wire [DATA_W-1:0] rd_low = {{(DATA_W-LOW_W){1'b0}}, pc_r[LOW_W-1:0]};
  wire [DATA_W-1:0] rd_latch = {{(DATA_W-LATCH_W){1'b0}}, latch_r};
  wire [DATA_W-1:0] rd_config = {{(DATA_W-SEL_W){1'b0}}, size_sel_r};
  wire [DATA_W-1:0] rd_status = {{(DATA_W-pcs_pkg::ST_SEEN_BIT-1){1'b0}}, op_seen_r,
                                 {(pcs_pkg::ST_SEEN_BIT-OP_W){1'b0}}, last_op_r};
  // the upper counter bits are never returned to software
  wire [DATA_W-1:0] rd_mux = hit_low ? rd_low :
                             hit_latch ? rd_latch :
                             hit_config ? rd_config :
                             hit_status ? rd_status : '0;

  // ---------------------------------------------------------------
  // core op decode
  // ---------------------------------------------------------------
  pcs_pkg::pcs_op_type op;
  assign op = pcs_pkg::pcs_op_type'(op_kind);

  // a software write of the low byte pre-empts a core op in that cycle
  wire core_go = op_valid && !sw_low_we;
  wire is_seq = core_go && (op == pcs_pkg::OP_SEQ);
  wire is_jump = core_go && (op == pcs_pkg::OP_JUMP);
  wire is_call = core_go && (op == pcs_pkg::OP_CALL);
  wire is_ret = core_go && (op == pcs_pkg::OP_RETURN || op == pcs_pkg::OP_RETURN_WITH_LITERAL_OP ||
                            op == pcs_pkg::OP_RETURN_FROM_INTERRUPT_OP);
  wire is_pclw = core_go && (op == pcs_pkg::OP_PCL_WRITE);
  wire is_irq = core_go && (op == pcs_pkg::OP_IRQ);

  // ---------------------------------------------------------------
  // candidate addresses, all folded into implemented memory
  // ---------------------------------------------------------------
  wire [PC_W-1:0] pc_inc_raw = pc_r + pcs_pkg::PC_ONE;
  wire [PC_W-1:0] jump_raw = {latch_r[pcs_pkg::LATCH_JUMP_HI:pcs_pkg::LATCH_JUMP_LO],
                              op_target};
  wire [LOW_W-1:0] low_src = sw_low_we ? pwdata[LOW_W-1:0] : op_data;
  wire [PC_W-1:0] pclw_raw = {latch_r, low_src};

  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] jump_addr;
  logic [PC_W-1:0] pclw_addr;
  logic [PC_W-1:0] ret_addr;

  pcs_addr_wrap #(.MEM_WORDS(MEM_WORDS)) u_wrap_inc (
    .size_sel(size_sel_r),
    .addr_in(pc_inc_raw),
    .addr_out(pc_inc)
  );

  pcs_addr_wrap #(.MEM_WORDS(MEM_WORDS)) u_wrap_jump (
    .size_sel(size_sel_r),
    .addr_in(jump_raw),
    .addr_out(jump_addr)
  );

  pcs_addr_wrap #(.MEM_WORDS(MEM_WORDS)) u_wrap_pclw (
    .size_sel(size_sel_r),
    .addr_in(pclw_raw),
    .addr_out(pclw_addr)
  );

  // a popped entry may predate a shrink of the size select, so refold it
  pcs_addr_wrap #(.MEM_WORDS(MEM_WORDS)) u_wrap_ret (
    .size_sel(size_sel_r),
    .addr_in(stk.pop_data),
    .addr_out(ret_addr)
  );

  // ---------------------------------------------------------------
  // stack control
  // ---------------------------------------------------------------
  // calls save the address after the call; interrupts save the
  // instruction that was displaced by the vector
  assign stk.push = is_call || is_irq;
  assign stk.pop = is_ret;
  assign stk.push_data = is_irq ? pc_r : pc_inc;

  // ---------------------------------------------------------------
  // next counter value
  // ---------------------------------------------------------------
  always_comb begin
    pc_nxt = pc_r;
    if (sw_low_we || is_pclw) begin
      pc_nxt = pclw_addr;
    end else if (is_jump || is_call) begin
      pc_nxt = jump_addr;
    end else if (is_ret) begin
      pc_nxt = ret_addr;
    end else if (is_irq) begin
      pc_nxt = pcs_pkg::IRQ_VECTOR;
    end else if (is_seq) begin
      pc_nxt = pc_inc;
    end
  end

  // only explicit writes change the latch; push and pop never do
  always_comb begin
    latch_nxt = latch_r;
    if (sw_latch_we) begin
      latch_nxt = pwdata[LATCH_W-1:0];
    end else if (latch_wr) begin
      latch_nxt = latch_data[LATCH_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= pcs_pkg::RESET_VECTOR;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_r <= pcs_pkg::LATCH_RESET;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      size_sel_r <= SEL_RESET;
    end else if (sw_config_we) begin
      size_sel_r <= pwdata[SEL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_op_r <= '0;
      op_seen_r <= 1'b0;
    end else if (core_go) begin
      last_op_r <= op_kind;
      op_seen_r <= 1'b1;
    end
  end

  // one access cycle per transfer; data and error settle at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= apb_setup;
      pslverr_r <= apb_setup && !hit_any;
      prdata_r <= (apb_setup && !pwrite) ? rd_mux : '0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign fetch_addr = pc_r;
  assign pc_low = pc_r[LOW_W-1:0];
  assign pc_high_latch = latch_r;
endmodule

// file: tb/pcs_pc_unit_sva.sv
// port checker for the program sequencer
// assumes one pclk domain and the designer's fixed one-cycle answers
`timescale 1ns/1ns
module pcs_pc_unit_sva #(
  parameter int MEM_WORDS = 2048,
  parameter int STACK_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic op_valid,
  input wire logic [2:0] op_kind,
  input wire logic [10:0] op_target,
  input wire logic [7:0] op_data,
  input wire logic latch_wr,
  input wire logic [7:0] latch_data,
  input wire logic [12:0] fetch_addr,
  input wire logic [7:0] pc_low,
  input wire logic [4:0] pc_high_latch
);
  wire apb_wr = psel && penable && pready && pwrite;
  wire pcl_wr = apb_wr && paddr == 12'h000;
  // a core op is dropped when an APB low-byte write commits on the same edge
  wire op_ok = op_valid && !pcl_wr;
  wire jmp = op_ok && (op_kind == 3'h1 || op_kind == 3'h2);
  wire stk = op_valid && op_kind inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  wire keep = stk && !latch_wr && !(apb_wr && paddr == 12'h004);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_op(logic [2:0] k);
    op_ok && op_kind == k;
  endsequence
  sequence s_rd_low;
    psel && !penable && !pwrite && paddr == 12'h000 && !op_valid ##1 psel && penable;
  endsequence
  AST_SEQ_STEP: assert property (
    s_op(3'h0) |=> fetch_addr[8:0] == $past(fetch_addr[8:0]) + 9'h001)
    else $error("sequential step wrong");
  AST_IN_MEMORY: assert property (
    fetch_addr < 13'(MEM_WORDS)) else $error("fetch address beyond memory");
  AST_IRQ_VECTOR: assert property (
    s_op(3'h7) |=> fetch_addr == 13'h0004) else $error("interrupt vector wrong");
  AST_JUMP_LOW: assert property (
    jmp |=> fetch_addr[8:0] == $past(op_target[8:0])) else $error("jump target wrong");
  AST_PCL_OP: assert property (
    s_op(3'h6) |=> pc_low == $past(op_data)) else $error("core low byte write wrong");
  AST_PCL_APB: assert property (
    pcl_wr |=> pc_low == $past(pwdata[7:0]) && fetch_addr[8] == $past(pc_high_latch[0]))
    else $error("bus low byte write wrong");
  AST_LATCH_KEEP: assert property (
    keep |=> $stable(pc_high_latch)) else $error("stack op changed latch");
  AST_READ_LOW: assert property (
    s_rd_low |-> pready && prdata == {24'h000000, pc_low}) else $error("low byte read wrong");
  AST_RESET_CLEAR: assert property (
    @(posedge pclk) disable iff (1'b0) !presetn |-> fetch_addr == 13'h0000 && pc_low == 8'h00)
    else $error("counter not cleared in reset");
endmodule

bind pcs_pc_unit pcs_pc_unit_sva #(.MEM_WORDS(MEM_WORDS), .STACK_DEPTH(STACK_DEPTH)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .op_valid(op_valid), .op_kind(op_kind), .op_target(op_target), .op_data(op_data),
  .latch_wr(latch_wr), .latch_data(latch_data), .fetch_addr(fetch_addr), .pc_low(pc_low),
  .pc_high_latch(pc_high_latch)
);

// file: tb/pcs_core_model.sv
// stand-in for the core decoder: one op or latch write per call
// assumes tasks are entered right after a rising pclk edge
`timescale 1ns/1ns
module pcs_core_model (
  input wire logic pclk,
  output logic op_valid,
  output logic [2:0] op_kind,
  output logic [10:0] op_target,
  output logic [7:0] op_data,
  output logic latch_wr,
  output logic [7:0] latch_data
);
  initial begin
    op_valid = 1'b0;
    op_kind = 3'h0;
    op_target = 11'h000;
    op_data = 8'h00;
    latch_wr = 1'b0;
    latch_data = 8'h00;
  end
  task automatic issue(input logic [2:0] k, input logic [10:0] t, input logic [7:0] d);
    op_valid <= 1'b1;
    op_kind <= k;
    op_target <= t;
    op_data <= d;
    @(posedge pclk);
    op_valid <= 1'b0;
    // released target and data flip so a stale value never passes for a held one
    op_target <= ~t;
    op_data <= ~d;
  endtask
  task automatic load_latch(input logic [7:0] v);
    latch_wr <= 1'b1;
    latch_data <= v;
    @(posedge pclk);
    latch_wr <= 1'b0;
    latch_data <= ~v;
  endtask
endmodule

// file: tb/program_counter_stack_tb_top.sv
// self-checking bench for the program sequencer and its APB registers
// assumes pcs_core_model drives the core side; default 2K memory
`timescale 1ns/1ns
module program_counter_stack_tb_top;
  typedef struct {logic [2:0] k; logic [10:0] t; logic [7:0] d; logic [12:0] pc;} pcs_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, op_valid, latch_wr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] op_kind;
  logic [10:0] op_target;
  logic [7:0] op_data, latch_data, pc_low;
  logic [12:0] fetch_addr;
  logic [4:0] pc_high_latch;
  logic [12:0] pushed [9];
  pcs_row_type rows [12];
  int n_fail, comparisons;
  pcs_pc_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_kind(op_kind), .op_target(op_target),
    .op_data(op_data), .latch_wr(latch_wr), .latch_data(latch_data),
    .fetch_addr(fetch_addr), .pc_low(pc_low), .pc_high_latch(pc_high_latch));
  pcs_core_model u_core (.pclk(pclk), .op_valid(op_valid), .op_kind(op_kind),
    .op_target(op_target), .op_data(op_data), .latch_wr(latch_wr), .latch_data(latch_data));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no cycle count is assumed here: only the watchdog ends a hung access
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
  // the idle edge after each op lets fetch_addr be read while it stands still
  task automatic step(input logic [2:0] k, input logic [10:0] t, input logic [7:0] d);
    u_core.issue(k, t, d);
    @(posedge pclk);
  endtask
  task automatic close_out;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge pclk);
    n_fail++;
    close_out;
  end
  initial begin
    // kinds: 0 seq, 1 jump, 2 call, 3 return, 4 literal return, 5 irq return, 6 low write, 7 irq
    rows = '{'{3'h0, 11'h000, 8'h00, 13'h0001}, '{3'h0, 11'h000, 8'h00, 13'h0002},
      '{3'h1, 11'h7FE, 8'h00, 13'h07FE}, '{3'h0, 11'h000, 8'h00, 13'h07FF},
      '{3'h0, 11'h000, 8'h00, 13'h0000}, '{3'h6, 11'h000, 8'h40, 13'h0040},
      '{3'h7, 11'h000, 8'h00, 13'h0004}, '{3'h5, 11'h000, 8'h00, 13'h0040},
      '{3'h2, 11'h123, 8'h00, 13'h0123}, '{3'h4, 11'h000, 8'h00, 13'h0041},
      '{3'h2, 11'h200, 8'h00, 13'h0200}, '{3'h3, 11'h000, 8'h00, 13'h0042}};
    {psel, penable, pwrite, paddr, pwdata} = {3'h0, 12'h000, 32'h0};
    // an update, not a blocking write, so the flops already wait for the reset edge
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("fetch_in_reset", {19'h0, fetch_addr}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk("reg_reset", rd, (i == 2) ? 32'h2 : 32'h0);
    end
    foreach (rows[i]) begin
      step(rows[i].k, rows[i].t, rows[i].d);
      chk("fetch", {19'h0, fetch_addr}, {19'h0, rows[i].pc});
    end
    u_core.load_latch(8'hFF);
    apb(1'b1, 12'h000, 32'hA5);
    chk("pcl_bus_write", {19'h0, fetch_addr}, 32'h7A5);
    apb(1'b0, 12'h000, 32'h0);
    chk("pcl_read", rd, 32'hA5);
    for (int i = 0; i < 9; i++) begin
      pushed[i] = (i == 0) ? 13'h07A6 : 13'(16 * i + 1);
      step(3'h2, 11'(16 * (i + 1)), 8'h00);
    end
    // nine pops after nine pushes: the oldest slot was overwritten, pointer wraps
    for (int j = 0; j < 9; j++) begin
      step(3'h3, 11'h000, 8'h00);
      chk("pop", {19'h0, fetch_addr}, {19'h0, pushed[(j == 8) ? 8 : 8 - j]});
    end
    chk("latch_kept", {27'h0, pc_high_latch}, 32'h1F);
    apb(1'b1, 12'h008, 32'h0);
    step(3'h6, 11'h000, 8'hFF);
    chk("pcl_512", {19'h0, fetch_addr}, 32'h1FF);
    step(3'h0, 11'h000, 8'h00);
    chk("wrap_512", {19'h0, fetch_addr}, 32'h0);
    apb(1'b1, 12'h008, 32'h2);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    apb(1'b1, 12'h00C, 32'hFF);
    apb(1'b0, 12'h00C, 32'h0);
    chk("status_no_flags", rd, 32'h10);
    apb(1'b1, 12'h004, 32'h9);
    apb(1'b1, 12'h008, 32'h1);
    step(3'h6, 11'h000, 8'h34);
    chk("pcl_1k", {19'h0, fetch_addr}, 32'h134);
    chk("latch_bus", {27'h0, pc_high_latch}, 32'h9);
    apb(1'b1, 12'h008, 32'h2);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("fetch_mid_reset", {19'h0, fetch_addr}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    step(3'h0, 11'h000, 8'h00);
    chk("step_after_reset", {19'h0, fetch_addr}, 32'h1);
    close_out;
  end
endmodule
